// ==== hw/svd_pkg.sv ====
// package of constants for the supply voltage detect flag block
// Summary of operation
// - detection runs only while control bit 0 is written as one
// - while enabled, flags follow the comparators continuously, no trigger needed
// - flags are valid only 20 us after enable; ready bit shows this
// - high flag, bit 2, set only while supply is above high threshold
// - low flag, bit 1, set only while supply is below low threshold
// - enabled low flag sets request bit 5, latched until a one is written to it or reset
// - latched request raises the interrupt only when its mask bit is set
package svd_pkg;
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] SVD_CTRL_OFS  = 8'h0C;
  localparam logic [7:0] SVD_REQ_OFS   = 8'h10;
  localparam logic [7:0] SVD_MASK_OFS  = 8'h14;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SVD_EN_BIT    = 0;
  localparam int SVD_LOW_BIT   = 1;
  localparam int SVD_HIGH_BIT  = 2;
  localparam int SVD_READY_BIT = 3;
  localparam int SVD_REQ_BIT   = 5;
  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [7:0] SVD_CTRL_RST = 8'h00;
  localparam logic [7:0] SVD_MASK_RST = 8'h00;
  localparam int SVD_CLK_HZ    = 10_000_000;
  localparam int SVD_SETTLE_US = 20;
  localparam int SVD_SETTLE_CYC =
    (SVD_SETTLE_US * (SVD_CLK_HZ / 1_000_000) < 1) ? 1 :
    SVD_SETTLE_US * (SVD_CLK_HZ / 1_000_000);
endpackage : svd_pkg

// ==== hw/svd_sync.sv ====
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module svd_sync (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_reg;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      q_o      <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // svd_sync

// ==== hw/svd_top.sv ====
// supply voltage detect flags with avalon-mm register slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module svd_top
  import svd_pkg::*;
#(
  parameter int SETTLE_CYC = svd_pkg::SVD_SETTLE_CYC
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // analog comparators
  input  wire logic        cmp_above_high_i,
  input  wire logic        cmp_below_low_i,
  // interrupt
  output logic             irq_o
);
  import svd_pkg::*;

  // 16-bit settle counter; ready must stay low two cycles after enable
  if (SETTLE_CYC < 2 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rstn_reg;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rstn_reg     <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rstn_reg     <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // comparator synchronisers
  // ****************************************************************
  logic above_s;
  logic below_s;
  svd_sync u_sync_high (
    .mclk_i (mclk_i),
    .rstn_i (rstn_reg),
    .d_i    (cmp_above_high_i),
    .q_o    (above_s)
  );
  svd_sync u_sync_low (
    .mclk_i (mclk_i),
    .rstn_i (rstn_reg),
    .d_i    (cmp_below_low_i),
    .q_o    (below_s)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // one wait cycle per access keeps read data registered
  logic        ack_reg;
  logic        enable_reg;
  logic        low_flag_reg;
  logic        high_flag_reg;
  logic        ready_reg;
  logic        req_reg;
  logic        mask_reg;
  logic [15:0] settle_reg;
  logic [31:0] rdata_reg;

  wire access    = avs_read_i | avs_write_i;
  wire hit_ctrl  = avs_address_i == SVD_CTRL_OFS;
  wire hit_req   = avs_address_i == SVD_REQ_OFS;
  wire hit_mask  = avs_address_i == SVD_MASK_OFS;
  wire wr_take   = avs_write_i & ack_reg & avs_byteenable_i[0];
  wire wr_ctrl   = wr_take & hit_ctrl;
  wire wr_req    = wr_take & hit_req;
  wire wr_mask   = wr_take & hit_mask;
  wire rd_take   = avs_read_i & ~ack_reg;

  assign avs_waitrequest_o = access & ~ack_reg;

  wire [7:0] ctrl_view = {4'h0, ready_reg, high_flag_reg,
                          low_flag_reg, enable_reg};
  wire [7:0] req_view  = {2'h0, req_reg, 5'h00};
  wire [7:0] mask_view = {2'h0, mask_reg, 5'h00};
  wire [7:0] rd_sel    = hit_ctrl ? ctrl_view :
                         hit_req  ? req_view  :
                         hit_mask ? mask_view : 8'h00;

  always_ff @(posedge mclk_i or negedge rstn_reg) begin
    if (!rstn_reg) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (rd_take) begin
        rdata_reg <= {24'h00_0000, rd_sel};
      end
    end
  end
  assign avs_readdata_o = rdata_reg;

  // ****************************************************************
  // detection enable and settling
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rstn_reg) begin
    if (!rstn_reg) begin
      enable_reg <= SVD_CTRL_RST[SVD_EN_BIT];
    end else if (wr_ctrl) begin
      enable_reg <= avs_writedata_i[SVD_EN_BIT];
    end
  end

  // counter restarts on every enable; ready only after full settle
  wire [15:0] settle_next = (!enable_reg) ? 16'h0000 :
                            (ready_reg)   ? settle_reg :
                            settle_reg + 16'h0001;
  wire ready_next = enable_reg &
                    (ready_reg | (settle_next >= 16'(SETTLE_CYC)));
  always_ff @(posedge mclk_i or negedge rstn_reg) begin
    if (!rstn_reg) begin
      settle_reg <= 16'h0000;
      ready_reg  <= 1'b0;
    end else begin
      settle_reg <= settle_next;
      ready_reg  <= ready_next;
    end
  end

  // ****************************************************************
  // live flags
  // ****************************************************************
  wire high_next = enable_reg & above_s;
  wire low_next  = enable_reg & below_s;
  always_ff @(posedge mclk_i or negedge rstn_reg) begin
    if (!rstn_reg) begin
      high_flag_reg <= 1'b0;
      low_flag_reg  <= 1'b0;
    end else begin
      high_flag_reg <= high_next;
      low_flag_reg  <= low_next;
    end
  end

  // ****************************************************************
  // latched request and mask
  // ****************************************************************
  // set beats a same-cycle write-one clear so no event is lost
  wire req_set  = enable_reg & low_flag_reg;
  wire req_clr  = wr_req & avs_writedata_i[SVD_REQ_BIT];
  wire req_next = req_set | (req_reg & ~req_clr);
  always_ff @(posedge mclk_i or negedge rstn_reg) begin
    if (!rstn_reg) begin
      req_reg  <= 1'b0;
      mask_reg <= SVD_MASK_RST[SVD_REQ_BIT];
    end else begin
      req_reg <= req_next;
      if (wr_mask) begin
        mask_reg <= avs_writedata_i[SVD_REQ_BIT];
      end
    end
  end

  // global enable lives in the core; this level is held until cleared
  assign irq_o = req_reg & mask_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_en_write;
    @(posedge mclk_i) disable iff (!rstn_reg)
      wr_ctrl |=> enable_reg == $past(avs_writedata_i[SVD_EN_BIT]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("enable bit did not follow write");

  property p_high_track;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (enable_reg && above_s) |=> high_flag_reg;
  endproperty
  a_high_track: assert property (p_high_track)
    else $error("high flag missed comparator");

  property p_low_track;
    @(posedge mclk_i) disable iff (!rstn_reg)
      $past(enable_reg) |-> low_flag_reg == $past(below_s);
  endproperty
  a_low_track: assert property (p_low_track)
    else $error("low flag did not track comparator");

  property p_track_live;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (enable_reg && $changed(above_s)) |=>
        high_flag_reg == $past(above_s) || !enable_reg;
  endproperty
  a_track_live: assert property (p_track_live)
    else $error("flag not updated in real time");

  property p_not_ready_early;
    @(posedge mclk_i) disable iff (!rstn_reg)
      $rose(enable_reg) |-> !ready_reg [*2];
  endproperty
  a_not_ready_early: assert property (p_not_ready_early)
    else $error("ready raised too early");

  property p_ready_settle;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (ready_reg && !$past(ready_reg)) |->
        settle_reg >= 16'(SETTLE_CYC);
  endproperty
  a_ready_settle: assert property (p_ready_settle)
    else $error("ready before settle count");

  property p_req_latch;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (req_reg && !req_clr) |=> req_reg;
  endproperty
  a_req_latch: assert property (p_req_latch)
    else $error("request bit dropped without clear");

  property p_req_set;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (enable_reg && low_flag_reg) |=> req_reg;
  endproperty
  a_req_set: assert property (p_req_set)
    else $error("low flag did not set request");

  property p_irq_mask;
    @(posedge mclk_i) disable iff (!rstn_reg)
      irq_o == (req_reg && mask_reg);
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt not gated by mask");

  property p_off_quiet;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (!enable_reg && !$past(enable_reg)) |->
        !high_flag_reg && !low_flag_reg && !ready_reg;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("flags active while disabled");

  property p_en_hold;
    @(posedge mclk_i) disable iff (!rstn_reg)
      !wr_ctrl |=> $stable(enable_reg);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enable bit changed without write");

  property p_low_live;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (enable_reg && $changed(below_s)) |=> low_flag_reg == $past(below_s);
  endproperty
  a_low_live: assert property (p_low_live)
    else $error("low flag not updated in real time");

  property p_ready_hold;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (ready_reg && enable_reg) |=> ready_reg;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready lost while enabled");

  property p_flags_off;
    @(posedge mclk_i) disable iff (!rstn_reg)
      !enable_reg |=> !high_flag_reg && !low_flag_reg;
  endproperty
  a_flags_off: assert property (p_flags_off)
    else $error("flag raised while disabled");

  property p_req_quiet;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (!enable_reg && !req_reg) |=> !req_reg;
  endproperty
  a_req_quiet: assert property (p_req_quiet)
    else $error("request set while disabled");

  property p_req_clear;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (req_clr && !req_set) |=> !req_reg;
  endproperty
  a_req_clear: assert property (p_req_clear)
    else $error("request bit not cleared by write");

  property p_mask_write;
    @(posedge mclk_i) disable iff (!rstn_reg)
      wr_mask |=> mask_reg == $past(avs_writedata_i[SVD_REQ_BIT]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask bit did not follow write");

  property p_irq_rise;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (req_set && mask_reg && !wr_mask) |=> irq_o;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("unmasked request did not raise interrupt");

  property p_irq_masked;
    @(posedge mclk_i) disable iff (!rstn_reg)
      (!mask_reg && !wr_mask) |=> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("masked request raised interrupt");
endmodule // svd_top

// ==== tb/svd_top_tb.sv ====
// self-checking bench for the voltage detect flags
`timescale 1ns/1ps
module svd_top_tb;
  import svd_pkg::*;
  // short settle count keeps the run brief
  localparam int SC = 5;
  logic        mclk_i, rstn_i, avs_read_i, avs_write_i, a, b;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic        avs_waitrequest_o, cmp_above_high_i, cmp_below_low_i, irq_o;
  int          bad_count, n_checks, cyc;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  svd_top #(.SETTLE_CYC(SC)) svd_top_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .cmp_above_high_i(cmp_above_high_i), .cmp_below_low_i(cmp_below_low_i),
    .irq_o(irq_o)
  );
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic close_out;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // ******************************
  // avalon master: holds until waitrequest low
  // ******************************
  task automatic bus(logic rd, logic [7:0] ad, logic [31:0] d, logic [3:0] be);
    int n = 0;
    @(posedge mclk_i);
    avs_read_i       <= rd;
    avs_write_i      <= !rd;
    avs_address_i    <= ad;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) bad_count++;
    {avs_read_i, avs_write_i} <= 2'b00;
  endtask
  task automatic rd(logic [7:0] ad, logic [31:0] e, string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    bus(1'b1, ad, 32'h0, 4'h0);
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] d, logic [3:0] be = 4'hF);
    bus(1'b0, ad, d, be);
  endtask
  // comparator levels reach the flags three edges later
  task automatic cmp(input logic hi, input logic lo);
    @(posedge mclk_i);
    {cmp_above_high_i, cmp_below_low_i} <= {hi, lo};
    repeat (5) @(posedge mclk_i);
  endtask
  task automatic ck_irq(input string nm, input logic e);
    @(negedge mclk_i);
    ck(nm, 32'(e), 32'(irq_o));
  endtask
  // ******************************
  // read monitor: oldest note per accepted read
  // ******************************
  always @(posedge mclk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0) begin
      ck(nm_q.pop_front(), exp_q.pop_front(), avs_readdata_o);
    end
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    {avs_address_i, avs_read_i, avs_write_i} = '0;
    {avs_writedata_i, avs_byteenable_i} = '0;
    {cmp_above_high_i, cmp_below_low_i, rstn_i} = '0;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    void'($urandom(69422));
    rd(SVD_CTRL_OFS, 32'h0, "ctrl_rst");
    rd(SVD_REQ_OFS, 32'h0, "req_rst");
    rd(SVD_MASK_OFS, 32'h0, "mask_rst");
    wr(8'h20, 32'hFF);
    rd(8'h20, 32'h0, "unmapped");
    $display("test reset_values done");
    cmp(1'b1, 1'b1);
    rd(SVD_CTRL_OFS, 32'h0, "ctrl_off");
    rd(SVD_REQ_OFS, 32'h0, "req_off");
    cmp(1'b0, 1'b0);
    wr(SVD_CTRL_OFS, 32'h01);
    rd(SVD_CTRL_OFS, 32'h01, "ctrl_settling");
    repeat (SC + 5) @(posedge mclk_i);
    rd(SVD_CTRL_OFS, 32'h09, "ctrl_ready");
    $display("test enable done");
    for (int i = 0; i < 8; i++) begin
      a = 1'($urandom);
      b = a ? 1'b0 : 1'($urandom);
      cmp(a, b);
      rd(SVD_CTRL_OFS, {28'h0, 1'b1, a, b, 1'b1}, "ctrl_live");
    end
    $display("test live_flags done");
    cmp(1'b0, 1'b0);
    wr(SVD_REQ_OFS, 32'h20);
    rd(SVD_REQ_OFS, 32'h0, "req_clear");
    cmp(1'b0, 1'b1);
    rd(SVD_REQ_OFS, 32'h20, "req_set");
    ck_irq("irq_masked", 1'b0);
    wr(SVD_MASK_OFS, 32'h20, 4'h0);
    rd(SVD_MASK_OFS, 32'h0, "mask_be0");
    wr(SVD_MASK_OFS, 32'h20);
    ck_irq("irq_unmasked", 1'b1);
    wr(SVD_REQ_OFS, 32'h20);
    rd(SVD_REQ_OFS, 32'h20, "req_set_wins");
    cmp(1'b0, 1'b0);
    rd(SVD_REQ_OFS, 32'h20, "req_latched");
    wr(SVD_REQ_OFS, 32'h20);
    rd(SVD_REQ_OFS, 32'h0, "req_cleared");
    ck_irq("irq_cleared", 1'b0);
    $display("test request done");
    cmp(1'b0, 1'b1);
    wr(SVD_CTRL_OFS, 32'h0);
    rd(SVD_CTRL_OFS, 32'h0, "ctrl_dis");
    wr(SVD_REQ_OFS, 32'h20);
    rd(SVD_REQ_OFS, 32'h0, "req_dis");
    ck_irq("irq_dis", 1'b0);
    wr(SVD_CTRL_OFS, 32'h01);
    repeat (3) @(posedge mclk_i);
    ck_irq("irq_powerup", 1'b1);
    $display("test disable done");
    close_out();
  end
endmodule // svd_top_tb
